// [bench/flip_core_model.sv]
// behavioural processor core that takes requests and returns from routines
`timescale 1ns/10ps
`default_nettype none
module flip_core_model (
    input  wire logic       clk_sys_in,
    input  wire logic       arst_n_in,
    input  wire logic       req_in,
    input  wire logic       take_en_in,
    input  wire logic [7:0] svc_len_in,
    input  wire logic       bad_ret_in,
    output var  logic       take_out,
    output var  logic       ret_out,
    output var  logic       busy_out
);
    logic [3:0] depth_q;
    logic [7:0] cnt_q;
    logic       ret_q;
    // take a request in the cycle it is offered
    assign take_out = req_in & take_en_in;
    // innermost routine returns svc_len+2 cycles after the last take or return
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            depth_q <= 4'h0;
            cnt_q <= 8'h0;
            ret_q <= 1'b0;
        end else begin
            ret_q <= depth_q != 4'h0 && cnt_q == svc_len_in && !ret_q && !take_out;
            cnt_q <= (take_out || ret_q) ? 8'h0 : cnt_q + 8'h1;
            depth_q <= depth_q + {3'h0, take_out} - {3'h0, ret_q};
        end
    end
    assign ret_out = ret_q | bad_ret_in;
    assign busy_out = depth_q != 4'h0;
endmodule // flip_core_model
`default_nettype wire

// [bench/flip_sva.sv]
// assertion checker on the prioritizer top-level ports
`timescale 1ns/10ps
`default_nettype none
module flip_sva (
    input wire logic        clk_sys_in,
    input wire logic        arst_n_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_we_in,
    input wire logic [11:0] wb_adr_in,
    input wire logic [3:0]  wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic        wb_ack_out,
    input wire logic        core_take_in,
    input wire logic        core_return_in,
    input wire logic        core_irq_req_out,
    input wire logic [15:0] core_vector_out,
    input wire logic [3:0]  core_src_out,
    input wire logic [1:0]  core_level_out,
    input wire logic        evt_irq_out
);
    localparam [59:0] VIX = 60'he94d83c72b61a50; // vector slot per polling position
    logic       ga_q;  // shadow of global enable
    logic [2:0] msk_q; // shadow of event mask
    logic [3:0] isv_q; // shadow of in-service levels
    wire        wr  = wb_ack_out & wb_cyc_in & wb_stb_in & wb_we_in & wb_sel_in[0];
    wire        tk  = core_take_in & core_irq_req_out;
    // highest level in service plus one, zero when idle
    wire  [2:0] top = isv_q[3] ? 3'h4 : isv_q[2] ? 3'h3 : isv_q[1] ? 3'h2 : {2'h0, isv_q[0]};
    // shadows follow register writes and take/return traffic
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ga_q <= 1'b0;
            msk_q <= 3'h0;
            isv_q <= 4'h0;
        end else begin
            if (wr && wb_adr_in[11:2] == 10'h0a8) ga_q <= wb_dat_in[7];
            if (wr && wb_adr_in[11:2] == 10'h102) msk_q <= wb_dat_in[2:0];
            isv_q <= (isv_q & ~((core_return_in && top != 3'h0) ? 4'h1 << (top - 3'h1) : 4'h0))
                     | (tk ? 4'h1 << core_level_out : 4'h0);
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_bus_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence s_evt_late;
        ##2 evt_irq_out;
    endsequence
    AST_ACK_NEXT: assert property (s_bus_req |=> wb_ack_out) else $error("ack late");
    AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
    AST_GLOBAL_OFF: assert property (core_irq_req_out |-> $past(ga_q)) else $error("request while off");
    AST_VECTOR: assert property (core_irq_req_out |-> core_vector_out ==
        16'h0003 + {9'h0, VIX[core_src_out*4 +: 4], 3'h0}) else $error("wrong vector");
    AST_PREEMPT: assert property (core_irq_req_out |-> {1'b0, core_level_out} >= top)
        else $error("level not above service");
    AST_TAKE_DROP: assert property (tk |=> !core_irq_req_out) else $error("request after take");
    AST_ACCEPT_EVT: assert property (tk && msk_q[0] |-> s_evt_late) else $error("no accept event");
    AST_BADRET_EVT: assert property (core_return_in && isv_q == 4'h0 && msk_q[2] |-> s_evt_late)
        else $error("no bad return event");
endmodule // flip_sva
bind flip_top flip_sva i_sva (.clk_sys_in, .arst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
    .wb_sel_in, .wb_dat_in, .wb_ack_out, .core_take_in, .core_return_in, .core_irq_req_out,
    .core_vector_out, .core_src_out, .core_level_out, .evt_irq_out);
`default_nettype wire

// [bench/flip_tb.sv]
// self-checking bench for the interrupt prioritizer
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam [59:0] VIX = 60'he94d83c72b61a50; // vector slot per polling position
    logic        clk_sys_in = 1'b0;
    logic        arst_n_in = 1'b0;
    logic        cyc = 1'b0, we = 1'b0, bad_ret = 1'b0, take_en = 1'b0;
    logic        ack, take, ret, busy, req, evt;
    logic [11:0] adr = 12'h000;
    logic [3:0]  sel = 4'h0, sel_req = 4'h1;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic [7:0]  svc = 8'h02;
    logic [14:0] src = 15'h0;
    logic [15:0] vec;
    logic [3:0]  sid;
    logic [1:0]  lvl;
    logic [3:0]  log_q[$];
    logic [9:0]  idx_t[6] = '{10'h0a8, 10'h0e8, 10'h0b8, 10'h0b7, 10'h0f8, 10'h0f7};
    logic [7:0]  msk_t[6] = '{8'hff, 8'hff, 8'h7f, 8'h7f, 8'hff, 8'hff};
    int          fail_count = 0, cmp_count = 0, cyc_n = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    flip_top i_dut (.clk_sys_in, .arst_n_in, .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(dat_o), .wb_ack_out(ack),
        .src_req_in(src), .core_take_in(take), .core_return_in(ret), .core_irq_req_out(req),
        .core_vector_out(vec), .core_src_out(sid), .core_level_out(lvl), .evt_irq_out(evt));
    flip_core_model i_core (.clk_sys_in, .arst_n_in, .req_in(req), .take_en_in(take_en),
        .svc_len_in(svc), .bad_ret_in(bad_ret), .take_out(take), .ret_out(ret), .busy_out(busy));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one classic wishbone cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
        @(posedge clk_sys_in);
        cyc <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        sel <= sel_req;
        do @(posedge clk_sys_in); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        sel <= 4'h0;
    endtask
    task automatic rd(input logic [9:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk($sformatf("reg %h", idx), {24'h0, e}, rdat);
    endtask
    // raise sources and compare the order in which the core took them
    task automatic run(input logic [14:0] m, input logic [59:0] ord, input int n);
        @(posedge clk_sys_in);
        for (int b = 0; b < 15; b++) if (m[b]) src[b] <= 1'b1;
        for (int i = 0; i < 400 && log_q.size() < n; i++) @(posedge clk_sys_in);
        chk("taken count", n, log_q.size());
        for (int i = 0; i < n; i++) chk("taken source", 32'(ord[i*4 +: 4]), 32'(log_q[i]));
    endtask
    task automatic idle;
        for (int i = 0; i < 500 && (busy || src != 15'h0); i++) @(posedge clk_sys_in);
        chk("idle", 32'h0, {16'h0, busy, src});
        log_q.delete();
    endtask
    // timeout counts as a mismatch and ends the run
    always @(posedge clk_sys_in) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            fail_count++;
            complete_run;
        end
    end
    // take log, vector check and flag clearing by the service routine
    always @(posedge clk_sys_in) begin
        if (take && req) begin
            log_q.push_back(sid);
            chk("vector", 32'h3 + 32'(VIX[sid*4 +: 4]) * 8, {16'h0, vec});
            src[sid] <= 1'b0;
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        foreach (idx_t[i]) rd(idx_t[i], 8'h00);
        foreach (idx_t[i]) begin
            bus(1'b1, idx_t[i], 8'hff);
            rd(idx_t[i], msk_t[i]);
        end
        bus(1'b1, 10'h0a0, 8'hff);
        rd(10'h0a0, 8'h00);
        sel_req = 4'h0;
        bus(1'b1, 10'h0e8, 8'h00);
        sel_req = 4'h1;
        rd(10'h0e8, 8'hff);
        $display("test registers done");
        for (int i = 2; i < 6; i++) bus(1'b1, idx_t[i], 8'h00);
        bus(1'b1, 10'h0a8, 8'h7f);
        take_en <= 1'b1;
        src <= 15'h7fff;
        repeat (8) @(posedge clk_sys_in);
        chk("request", 32'h0, {31'h0, req});
        bus(1'b1, 10'h102, 8'h07);
        bus(1'b1, 10'h0a8, 8'hff);
        run(15'h0, 60'hedcba9876543210, 15);
        idle;
        bus(1'b1, 10'h0b7, 8'h10);
        bus(1'b1, 10'h0b8, 8'h10);
        bus(1'b1, 10'h0f7, 8'h80);
        bus(1'b1, 10'h0f8, 8'h01);
        run(15'h5011, 60'h04ec, 4);
        idle;
        $display("test order and levels done");
        svc <= 8'h14;
        run(15'h0001, 60'h0, 1);
        run(15'h4040, 60'h6e0, 3);
        idle;
        rd(10'h100, 8'h00);
        $display("test preemption done");
        chk("event irq", 32'h1, {31'h0, evt});
        rd(10'h101, 8'h03);
        bus(1'b1, 10'h101, 8'h03);
        rd(10'h101, 8'h00);
        bad_ret <= 1'b1;
        @(posedge clk_sys_in);
        bad_ret <= 1'b0;
        bus(1'b1, 10'h102, 8'h00);
        rd(10'h101, 8'h04);
        chk("event irq", 32'h0, {31'h0, evt});
        bus(1'b1, 10'h102, 8'h04);
        repeat (2) @(posedge clk_sys_in);
        chk("event irq", 32'h1, {31'h0, evt});
        bus(1'b1, 10'h101, 8'h04);
        repeat (2) @(posedge clk_sys_in);
        chk("event irq", 32'h0, {31'h0, evt});
        $display("test events done");
        complete_run;
    end
endmodule // testbench
`default_nettype wire

// [hw/flip_arbiter.v]
// fixed-order, four-level priority resolver for the fifteen sources
`timescale 1ns/10ps
`default_nettype none
`include "flip_regs.vh"

module flip_arbiter (
    input  wire [14:0] elig_in,
    input  wire [29:0] lvl_flat_in,
    output wire        win_valid_out,
    output wire [3:0]  win_idx_out,
    output wire [1:0]  win_lvl_out
);

    // ------------------------------------------------------------
    // chain from the last polled source (index 14) down to the first (index 0)
    // ------------------------------------------------------------
    wire [15:0] chain_v;
    wire [63:0] chain_idx;
    wire [31:0] chain_lvl;

    assign chain_v[15]          = 1'b0;
    assign chain_idx[63:60]     = 4'h0;
    assign chain_lvl[31:30]     = 2'h0;

    // a source of equal or higher level, polled earlier, wins the stage
    genvar i;
    generate
        for (i = 0; i < 15; i = i + 1) begin : g_stage
            localparam [3:0] SRC_IDX = i;
            wire [1:0] lv;
            wire       take;
            assign lv   = lvl_flat_in[2*i+1:2*i];
            assign take = elig_in[i] & (~chain_v[i+1] | (lv >= chain_lvl[2*i+3:2*i+2]));
            assign chain_v[i]             = chain_v[i+1] | elig_in[i];
            assign chain_idx[4*i+3:4*i]   = take ? SRC_IDX : chain_idx[4*i+7:4*i+4];
            assign chain_lvl[2*i+1:2*i]   = take ? lv : chain_lvl[2*i+3:2*i+2];
        end
    endgenerate

    assign win_valid_out = chain_v[0];
    assign win_idx_out   = chain_idx[3:0];
    assign win_lvl_out   = chain_lvl[1:0];

endmodule // flip_arbiter
`default_nettype wire

// [hw/flip_regs.vh]
// register map, field positions and constants of the interrupt prioritizer
`ifndef FLIP_REGS_VH
`define FLIP_REGS_VH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define FLIP_IDX_EN0      10'h0a8
`define FLIP_IDX_LVLHI0   10'h0b7
`define FLIP_IDX_LVLLO0   10'h0b8
`define FLIP_IDX_EN1      10'h0e8
`define FLIP_IDX_LVLHI1   10'h0f7
`define FLIP_IDX_LVLLO1   10'h0f8
`define FLIP_IDX_STATE    10'h100
`define FLIP_IDX_EVT_STS  10'h101
`define FLIP_IDX_EVT_MASK 10'h102

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FLIP_RST_REG8     8'h00
`define FLIP_RST_EVT      3'h0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FLIP_GLOBAL_EN_BIT 7
`define FLIP_GRP0_MASK    8'h7f
`define FLIP_EVT_ACCEPT   0
`define FLIP_EVT_PREEMPT  1
`define FLIP_EVT_BADRET   2
`define FLIP_ST_REQ_BIT   4
`define FLIP_ST_LVL_LSB   5

// ----------------------------------------------------------------
// sources in polling order: 4-bit {group, bit} and vector index
// ----------------------------------------------------------------
`define FLIP_NSRC         15
`define FLIP_SRC_POS      60'hfb4ea3d92c81650
`define FLIP_SRC_VEC      60'he94d83c72b61a50
`define FLIP_VEC_BASE     16'h0003
`define FLIP_VEC_STEP_SH  3

`endif

// [hw/flip_top.v]
// interrupt enable, four-level prioritizer and wishbone register file
//
// How it works
// - global enable bit 7 gates all acceptance
// - enable group 0 bits ADC..ext0
// - enable group 1 bits timer2..capture0
// - level low bits group 0, bit 7 reserved
// - level high bits group 0, bit 7 reserved
// - level low bits group 1, same positions
// - level high bits group 1, bit 7 timer2
// - equal levels resolved by fixed polling order
// - high and low bit form level 0..3
// - only strictly higher level preempts running service
// - each source branches to its fixed vector
`timescale 1ns/10ps
`default_nettype none
`include "flip_regs.vh"

module flip_top (
    input  wire        clk_sys_in,
    input  wire        arst_n_in,
    // wishbone classic slave
    input  wire        wb_cyc_in,
    input  wire        wb_stb_in,
    input  wire        wb_we_in,
    input  wire [11:0] wb_adr_in,
    input  wire [3:0]  wb_sel_in,
    input  wire [31:0] wb_dat_in,
    output wire [31:0] wb_dat_out,
    output wire        wb_ack_out,
    // source request flags, polling order
    input  wire [14:0] src_req_in,
    // processor core side
    input  wire        core_take_in,
    input  wire        core_return_in,
    output wire        core_irq_req_out,
    output wire [15:0] core_vector_out,
    output wire [3:0]  core_src_out,
    output wire [1:0]  core_level_out,
    // event interrupt
    output wire        evt_irq_out
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    reg  [7:0]  en0_q;
    reg  [7:0]  en1_q;
    reg  [7:0]  lo0_q;
    reg  [7:0]  hi0_q;
    reg  [7:0]  lo1_q;
    reg  [7:0]  hi1_q;
    reg  [2:0]  evt_sts_q;
    reg  [2:0]  evt_mask_q;
    reg  [3:0]  in_svc_q;
    reg         req_q;
    reg  [15:0] vec_q;
    reg  [3:0]  src_q;
    reg  [1:0]  lvl_q;
    reg         ack_q;
    reg  [31:0] rdat_q;
    reg         int_q;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire        bus_req;
    wire        wr_commit;
    wire [9:0]  idx;
    wire [7:0]  wbyte;

    // request is answered one cycle later; write lands at the ack edge
    assign bus_req   = wb_cyc_in & wb_stb_in;
    assign wr_commit = bus_req & wb_we_in & ack_q & wb_sel_in[0];
    assign idx       = wb_adr_in[11:2];
    assign wbyte     = wb_dat_in[7:0];

    // ------------------------------------------------------------
    // per-source lookup of enable and level bits
    // ------------------------------------------------------------
    wire [15:0] en_all;
    wire [15:0] lo_all;
    wire [15:0] hi_all;
    wire [14:0] src_en;
    wire [29:0] src_lvl;
    wire        global_irq_enable;

    // merged groups: index {group, bit}
    assign en_all = {en1_q, 1'b0, en0_q[6:0]};
    assign lo_all = {lo1_q, lo0_q};
    assign hi_all = {hi1_q, hi0_q};
    assign global_irq_enable = en0_q[`FLIP_GLOBAL_EN_BIT];

    // each source picks its bits by its fixed position
    genvar s;
    generate
        for (s = 0; s < `FLIP_NSRC; s = s + 1) begin : g_src
            wire [59:0] pos_map;
            wire [3:0]  pos;
            assign pos_map = `FLIP_SRC_POS;
            assign pos     = pos_map[4*s+3:4*s];
            assign src_en[s] = en_all[pos];
            assign src_lvl[2*s+1:2*s] = {hi_all[pos], lo_all[pos]};
        end
    endgenerate

    // ------------------------------------------------------------
    // eligibility and arbitration
    // ------------------------------------------------------------
    wire [14:0] elig;
    wire        win_v;
    wire [3:0]  win_idx;
    wire [1:0]  win_lvl;

    // nothing is accepted while the global enable is low
    assign elig = src_req_in & src_en & {15{global_irq_enable}};

    flip_arbiter u_arb (
        .elig_in       (elig),
        .lvl_flat_in   (src_lvl),
        .win_valid_out (win_v),
        .win_idx_out   (win_idx),
        .win_lvl_out   (win_lvl)
    );

    // ------------------------------------------------------------
    // highest level now in service
    // ------------------------------------------------------------
    reg         svc_busy;
    reg  [1:0]  svc_lvl;

    always @* begin
        svc_busy = 1'b1;
        svc_lvl  = 2'h0;
        case (1'b1)
            in_svc_q[3]: svc_lvl = 2'h3;
            in_svc_q[2]: svc_lvl = 2'h2;
            in_svc_q[1]: svc_lvl = 2'h1;
            in_svc_q[0]: svc_lvl = 2'h0;
            default:     svc_busy = 1'b0;
        endcase
    end

    // a waiting request must beat the running level strictly
    wire        win_ok;
    assign win_ok = win_v & (~svc_busy | (win_lvl > svc_lvl));

    // ------------------------------------------------------------
    // vector of the winning source
    // ------------------------------------------------------------
    wire [59:0] vec_map;
    wire [3:0]  win_vidx;
    wire [15:0] win_vector;

    assign vec_map    = `FLIP_SRC_VEC;
    assign win_vidx   = vec_map[{win_idx, 2'b00} +: 4];
    assign win_vector = `FLIP_VEC_BASE + {9'h000, win_vidx, 3'h0};

    // ------------------------------------------------------------
    // in-service tracking
    // ------------------------------------------------------------
    wire        take_ok;
    reg  [3:0]  in_svc_d;

    assign take_ok = core_take_in & req_q;

    // return releases the top level first, then a take adds its own
    always @* begin
        in_svc_d = in_svc_q;
        if (core_return_in && svc_busy) begin
            in_svc_d[svc_lvl] = 1'b0;
        end
        if (take_ok) begin
            in_svc_d[lvl_q] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // event status with write-one-to-clear, set wins
    // ------------------------------------------------------------
    reg  [2:0]  evt_set;
    reg  [2:0]  evt_clr;
    wire [2:0]  evt_sts_d;

    always @* begin
        evt_set = 3'h0;
        evt_set[`FLIP_EVT_ACCEPT]  = take_ok;
        evt_set[`FLIP_EVT_PREEMPT] = take_ok & svc_busy;
        evt_set[`FLIP_EVT_BADRET]  = core_return_in & ~svc_busy;
        evt_clr = 3'h0;
        if (wr_commit && idx == `FLIP_IDX_EVT_STS) begin
            evt_clr = wbyte[2:0];
        end
    end

    assign evt_sts_d = (evt_sts_q & ~evt_clr) | evt_set;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            en0_q      <= `FLIP_RST_REG8;
            en1_q      <= `FLIP_RST_REG8;
            lo0_q      <= `FLIP_RST_REG8;
            hi0_q      <= `FLIP_RST_REG8;
            lo1_q      <= `FLIP_RST_REG8;
            hi1_q      <= `FLIP_RST_REG8;
            evt_mask_q <= `FLIP_RST_EVT;
        end else if (wr_commit) begin
            case (idx)
                `FLIP_IDX_EN0:      en0_q <= wbyte;
                `FLIP_IDX_EN1:      en1_q <= wbyte;
                `FLIP_IDX_LVLLO0:   lo0_q <= wbyte & `FLIP_GRP0_MASK;
                `FLIP_IDX_LVLHI0:   hi0_q <= wbyte & `FLIP_GRP0_MASK;
                `FLIP_IDX_LVLLO1:   lo1_q <= wbyte;
                `FLIP_IDX_LVLHI1:   hi1_q <= wbyte;
                `FLIP_IDX_EVT_MASK: evt_mask_q <= wbyte[2:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------
    reg  [7:0]  rbyte;

    always @* begin
        case (idx)
            `FLIP_IDX_EN0:      rbyte = en0_q;
            `FLIP_IDX_EN1:      rbyte = en1_q;
            `FLIP_IDX_LVLLO0:   rbyte = lo0_q;
            `FLIP_IDX_LVLHI0:   rbyte = hi0_q;
            `FLIP_IDX_LVLLO1:   rbyte = lo1_q;
            `FLIP_IDX_LVLHI1:   rbyte = hi1_q;
            `FLIP_IDX_STATE:    rbyte = {1'b0, lvl_q, req_q, in_svc_q};
            `FLIP_IDX_EVT_STS:  rbyte = {5'h00, evt_sts_q};
            `FLIP_IDX_EVT_MASK: rbyte = {5'h00, evt_mask_q};
            default:            rbyte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // bus handshake: ack one cycle after request, dropped next cycle
    // ------------------------------------------------------------
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= bus_req & ~ack_q;
            if (bus_req && !ack_q) begin
                rdat_q <= {24'h000000, rbyte};
            end
        end
    end

    // ------------------------------------------------------------
    // core request, service state and event interrupt
    // ------------------------------------------------------------
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            in_svc_q  <= 4'h0;
            req_q     <= 1'b0;
            vec_q     <= 16'h0000;
            src_q     <= 4'h0;
            lvl_q     <= 2'h0;
            evt_sts_q <= `FLIP_RST_EVT;
            int_q     <= 1'b0;
        end else begin
            in_svc_q  <= in_svc_d;
            // the take cycle withdraws the request so it is not taken twice
            req_q     <= win_ok & ~take_ok & ~core_return_in;
            if (win_ok) begin
                vec_q <= win_vector;
                src_q <= win_idx;
                lvl_q <= win_lvl;
            end
            evt_sts_q <= evt_sts_d;
            int_q     <= |(evt_sts_d & evt_mask_q);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_ack_out       = ack_q;
    assign wb_dat_out       = rdat_q;
    assign core_irq_req_out = req_q;
    assign core_vector_out  = vec_q;
    assign core_src_out     = src_q;
    assign core_level_out   = lvl_q;
    assign evt_irq_out      = int_q;

endmodule // flip_top
`default_nettype wire
